// >>> hw/sdr_consts.vh
`ifndef SDR_CONSTS_VH
`define SDR_CONSTS_VH
`define SDR_CLK_MHZ    125
`define SDR_BREAK_US   12000
`define SDR_SEC_US     1000000
`define SDR_OFS_CTRL   8'h00
`define SDR_OFS_TIMVAL 8'h04
`define SDR_OFS_BASE   8'h08
`define SDR_OFS_MIDX   8'h0c
`define SDR_OFS_MDATA  8'h10
`define SDR_OFS_DONE   8'h14
`define SDR_OFS_SIG    8'h18
`define SDR_OFS_ERRMON 8'h1c
`define SDR_OFS_STATUS 8'h20
`define SDR_OFS_ISTAT  8'h24
`define SDR_OFS_IMASK  8'h28
`define SDR_OFS_ERRCNT 8'h2c
`define SDR_CTRL_EN    8
`define SDR_ERR_IDX    8
`define SDR_RST_ADDR   7'h00
`define SDR_NN_MAX     6'h3f
`define SDR_OPT_WDOG   3'h0
`define SDR_OPT_OVR    3'h1
`define SDR_OPT_LOWV   3'h2
`define SDR_OPT_BATT   3'h3
`define SDR_OPT_FLASH  3'h4
`define SDR_IS_ACC     0
`define SDR_IS_RDY     1
`define SDR_IS_TO      2
`define SDR_IS_SENT    3
`endif

// >>> hw/sdr_responder.v
`timescale 1ns/100ps
`include "sdr_consts.vh"
// Behaviour
// - answer only own address, 0-9 or 10-126 character; addresses unique.
// - time/count field: tt seconds, nn values at most 63.
// - zero time returns stored values at once, no measurement run.
// - for M, signal ready as soon as data done, not waiting.
// - M or C measurement overrunning set time: silent, no values sent.
// - data query before data done gets no reply; for C, before set time elapses.
// - first value at base plus count times digit after M (0 for M).
// - V returns watchdog count, overrun count, memory signature in order.
// - I sends address, version, vendor/model id and firmware revision.
// - error monitor option 0-4 selects counter or battery reading.
// - indexed option copies the count then clears it.
// - battery option ignores index, never cleared.
// - service runs on activity but works only after break plus address.
// - bus line is control port 2 only.
module sdr_responder #(
  parameter [31:0] SEC_CYC   = `SDR_SEC_US * `SDR_CLK_MHZ,
  parameter [31:0] BREAK_CYC = `SDR_BREAK_US * `SDR_CLK_MHZ,
  parameter [63:0] ID_STR    = 64'h5844_5356_454e_3031, // Arbitrary value
  parameter [23:0] FW_REV    = 24'h30_30_31             // Arbitrary value
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        port2Line,
  input  wire        rxValid,
  input  wire [7:0]  rxChar,
  output reg         txValid,
  output reg  [7:0]  txChar,
  input  wire        txReady,
  output reg         measReq,
  input  wire        wdogEvent,
  input  wire        overrunEvent,
  input  wire        lowSupplyEvent,
  input  wire        flashErrEvent,
  input  wire [15:0] batteryLevel
);
  localparam [2:0] P_IDLE = 3'd0, P_ADDR = 3'd1, P_CMD = 3'd2,
                   P_ARG = 3'd3, P_SKIP = 3'd4;
  localparam [2:0] K_ACK = 3'd0, K_MRESP = 3'd1, K_SRQ = 3'd2,
                   K_DATA = 3'd3, K_IDENT = 3'd4;

  function [7:0] decChar;
    input [6:0] v;
    input       tens;
    reg   [6:0] q;
    begin
      q = tens ? (v / 7'd10) : (v % 7'd10);
      decChar = 8'h30 + {1'b0, q};
    end
  endfunction

  function [7:0] hexChar;
    input [3:0] n;
    begin
      hexChar = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h57 + {4'h0, n};
    end
  endfunction

  reg  [31:0] mem [0:255];
  reg  [6:0]  addr_q;
  reg         en_q;
  reg  [6:0]  tt_q;
  reg  [5:0]  nn_q;
  reg  [7:0]  base_q, midx_q, start_q;
  reg  [31:0] sig_q;
  reg  [15:0] wd_q, ov_q, low_q, fl_q, errRes_q;
  reg  [3:0]  istat_q, imask_q;
  reg         line1_q, line2_q;
  reg  [31:0] brkCnt_q;
  reg         brk_q;
  reg  [2:0]  pst_q;
  reg  [7:0]  cmd_q;
  reg  [3:0]  arg_q;
  reg         tmrRun_q, dataVal_q, vMode_q, cMode_q, srq_q;
  reg  [31:0] secCnt_q;
  reg  [6:0]  secLeft_q;
  reg         sending_q, sLast_q;
  reg  [2:0]  sKind_q;
  reg  [1:0]  sPh_q;
  reg  [3:0]  sCnt_q, sNib_q;
  reg  [5:0]  sVal_q, sTot_q;
  reg  [7:0]  nch;
  reg  [31:0] curVal;
  reg         bodyLast;

  wire       apbWr  = psel & penable & pwrite & pready;
  wire [7:0] ownCh  = (addr_q < 7'd10) ? 8'h30 + {1'b0, addr_q}
                                       : {1'b0, addr_q};
  wire       rxGo   = ce & rxValid & ~sending_q;
  wire       bang   = rxChar == 8'h21;
  wire       isDig  = rxChar >= 8'h30 && rxChar <= 8'h39;
  wire       exec   = rxGo & bang & (pst_q == P_CMD | pst_q == P_ARG);
  wire [7:0] cmdX   = (pst_q == P_CMD) ? 8'h00 : cmd_q;
  wire       isMeas = cmdX == 8'h4d || cmdX == 8'h43;
  wire [9:0] offs   = {4'h0, nn_q} * {6'h00, arg_q};
  wire       doneWr = apbWr && paddr == `SDR_OFS_DONE && pwdata[0];
  wire       doneOk = doneWr & measReq & tmrRun_q;
  wire       expire = tmrRun_q && secCnt_q == SEC_CYC - 32'd1
                      && secLeft_q == 7'd1;
  wire       qryOk  = dataVal_q & ~tmrRun_q;
  wire       sentEv = txValid & txReady & sLast_q & (sKind_q == K_DATA);
  wire       errWr  = apbWr && paddr == `SDR_OFS_ERRMON;
  wire [2:0] opt    = pwdata[2:0];
  wire       errClr = errWr & pwdata[`SDR_ERR_IDX];
  wire [3:0] idSh   = 4'd9 - sCnt_q;
  wire [3:0] revSh  = 4'd12 - sCnt_q;
  wire [63:0] idW   = ID_STR >> {idSh[2:0], 3'b000};
  wire [23:0] revW  = FW_REV >> {revSh[1:0], 3'b000};
  wire [3:0] isSet  = {sentEv, expire & measReq, doneOk,
                       exec & isMeas & en_q};

  // Break seen only on port 2 line, two-stage synchronised
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      line1_q  <= 1'b0;
      line2_q  <= 1'b0;
      brkCnt_q <= 32'h0;
      brk_q    <= 1'b0;
    end else if (ce) begin
      line1_q <= port2Line;
      line2_q <= line1_q;
      brk_q   <= 1'b0;
      if (!line2_q) begin
        brkCnt_q <= 32'h0;
      end else if (brkCnt_q != BREAK_CYC - 32'd1) begin
        brkCnt_q <= brkCnt_q + 32'h1;
        brk_q    <= brkCnt_q == BREAK_CYC - 32'd2;
      end
    end
  end

  // Characters after a foreign address are skipped up to its '!'
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pst_q <= P_IDLE;
      cmd_q <= 8'h00;
      arg_q <= 4'h0;
    end else if (ce) begin
      if (brk_q) begin
        pst_q <= P_ADDR;
      end else if (rxGo) begin
        case (pst_q)
          P_ADDR: pst_q <= (en_q && rxChar == ownCh) ? P_CMD : P_SKIP;
          P_CMD: begin
            cmd_q <= rxChar;
            arg_q <= 4'h0;
            pst_q <= bang ? P_ADDR : P_ARG;
          end
          P_ARG: begin
            if (bang) begin
              pst_q <= P_ADDR;
            end else if (isDig) begin
              arg_q <= rxChar[3:0];
            end else begin
              pst_q <= P_SKIP;
            end
          end
          P_SKIP: pst_q <= bang ? P_ADDR : P_SKIP;
          default: pst_q <= P_IDLE;
        endcase
      end
    end
  end

  // Measurement timing; M, C or V exec takes priority over done and expiry
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      measReq   <= 1'b0;
      tmrRun_q  <= 1'b0;
      dataVal_q <= 1'b0;
      vMode_q   <= 1'b0;
      cMode_q   <= 1'b0;
      start_q   <= 8'h00;
      secCnt_q  <= 32'h0;
      secLeft_q <= 7'h00;
    end else if (ce) begin
      if (tmrRun_q) begin
        secCnt_q <= (secCnt_q == SEC_CYC - 32'd1) ? 32'h0
                                                  : secCnt_q + 32'h1;
        if (secCnt_q == SEC_CYC - 32'd1) begin
          secLeft_q <= secLeft_q - 7'd1;
        end
      end
      if (exec && en_q && isMeas) begin
        start_q  <= base_q + offs[7:0];
        vMode_q  <= 1'b0;
        cMode_q  <= cmdX == 8'h43;
        secCnt_q <= 32'h0;
        secLeft_q <= tt_q;
        measReq  <= tt_q != 7'h00;
        tmrRun_q <= tt_q != 7'h00;
        dataVal_q <= tt_q == 7'h00;
      end else if (exec && cmdX == 8'h56) begin
        vMode_q   <= 1'b1;
        dataVal_q <= 1'b1;
        measReq   <= 1'b0;
        tmrRun_q  <= 1'b0;
      end else if (doneOk) begin
        measReq   <= 1'b0;
        dataVal_q <= 1'b1;
        tmrRun_q  <= cMode_q;
      end else if (expire) begin
        tmrRun_q <= 1'b0;
        measReq  <= 1'b0;
      end
    end
  end

  always @* begin
    curVal = mem[start_q + {2'b00, sVal_q}];
    if (vMode_q) begin
      case (sVal_q)
        6'd0:    curVal = {16'h0000, wd_q};
        6'd1:    curVal = {16'h0000, ov_q};
        default: curVal = sig_q;
      endcase
    end
    bodyLast = 1'b0;
    nch = 8'h00;
    case (sPh_q)
      2'd0: nch = ownCh;
      2'd2: nch = 8'h0d;
      2'd3: nch = 8'h0a;
      default: begin
        case (sKind_q)
          K_MRESP: begin
            bodyLast = sCnt_q == 4'd4;
            case (sCnt_q)
              4'd0: nch = 8'h30;
              4'd1: nch = decChar(vMode_q ? 7'h00 : tt_q, 1'b1);
              4'd2: nch = decChar(vMode_q ? 7'h00 : tt_q, 1'b0);
              4'd3: nch = decChar(vMode_q ? 7'h03 : {1'b0, nn_q}, 1'b1);
              default: nch = decChar(vMode_q ? 7'h03 : {1'b0, nn_q}, 1'b0);
            endcase
          end
          K_IDENT: begin
            bodyLast = sCnt_q == 4'd12;
            if (sCnt_q == 4'd0) begin
              nch = 8'h31;
            end else if (sCnt_q == 4'd1) begin
              nch = 8'h33;
            end else if (sCnt_q < 4'd10) begin
              nch = idW[7:0];
            end else begin
              nch = revW[7:0];
            end
          end
          K_DATA: begin
            bodyLast = sNib_q == 4'd8 && sVal_q == sTot_q - 6'd1;
            case (sNib_q)
              4'd0: nch = 8'h2b;
              4'd1: nch = hexChar(curVal[31:28]);
              4'd2: nch = hexChar(curVal[27:24]);
              4'd3: nch = hexChar(curVal[23:20]);
              4'd4: nch = hexChar(curVal[19:16]);
              4'd5: nch = hexChar(curVal[15:12]);
              4'd6: nch = hexChar(curVal[11:8]);
              4'd7: nch = hexChar(curVal[7:4]);
              default: nch = hexChar(curVal[3:0]);
            endcase
          end
          default: bodyLast = 1'b1;
        endcase
      end
    endcase
  end

  // Reply sequencer; a pending service request waits for the line
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sending_q <= 1'b0;
      sLast_q   <= 1'b0;
      sKind_q   <= K_ACK;
      sPh_q     <= 2'd0;
      sCnt_q    <= 4'h0;
      sNib_q    <= 4'h0;
      sVal_q    <= 6'h00;
      sTot_q    <= 6'h00;
      srq_q     <= 1'b0;
      txValid   <= 1'b0;
      txChar    <= 8'h00;
    end else if (ce) begin
      if (doneOk && !cMode_q) begin
        srq_q <= 1'b1;
      end
      if (!sending_q) begin
        sPh_q  <= 2'd0;
        sCnt_q <= 4'h0;
        sNib_q <= 4'h0;
        sVal_q <= 6'h00;
        sLast_q <= 1'b0;
        if (exec) begin
          case (cmdX)
            8'h00: sending_q <= 1'b1;
            8'h4d, 8'h43, 8'h56: sending_q <= en_q;
            8'h49: sending_q <= 1'b1;
            8'h44: sending_q <= qryOk;
            default: sending_q <= 1'b0;
          endcase
          sKind_q <= (cmdX == 8'h00) ? K_ACK :
                     (cmdX == 8'h49) ? K_IDENT :
                     (cmdX == 8'h44) ? K_DATA : K_MRESP;
          sTot_q <= (arg_q != 4'h0) ? 6'h00 :
                    vMode_q ? 6'd3 : nn_q;
        end else if (srq_q) begin
          srq_q     <= doneOk && !cMode_q;
          sending_q <= 1'b1;
          sKind_q   <= K_SRQ;
        end
      end else if (!txValid) begin
        txValid <= 1'b1;
        txChar  <= nch;
        case (sPh_q)
          2'd0: sPh_q <= (sKind_q == K_ACK || sKind_q == K_SRQ ||
                          (sKind_q == K_DATA && sTot_q == 6'h00))
                         ? 2'd2 : 2'd1;
          2'd1: begin
            sCnt_q <= sCnt_q + 4'h1;
            sNib_q <= (sNib_q == 4'd8) ? 4'h0 : sNib_q + 4'h1;
            if (sNib_q == 4'd8) begin
              sVal_q <= sVal_q + 6'h01;
            end
            if (bodyLast) begin
              sPh_q <= 2'd2;
            end
          end
          2'd2: sPh_q <= 2'd3;
          default: sLast_q <= 1'b1;
        endcase
      end else if (txReady) begin
        txValid <= 1'b0;
        if (sLast_q) begin
          sending_q <= 1'b0;
        end
      end
    end
  end

  always @(posedge clk) begin
    if (ce && apbWr && paddr == `SDR_OFS_MDATA) begin
      mem[midx_q] <= pwdata;
    end
  end

  // Counters saturate; an event in the clearing cycle counts as one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_q <= 16'h0000;
      ov_q <= 16'h0000;
      low_q <= 16'h0000;
      fl_q <= 16'h0000;
      errRes_q <= 16'h0000;
    end else if (ce) begin
      if (errWr) begin
        case (opt)
          `SDR_OPT_WDOG:  errRes_q <= wd_q;
          `SDR_OPT_OVR:   errRes_q <= ov_q;
          `SDR_OPT_LOWV:  errRes_q <= low_q;
          `SDR_OPT_BATT:  errRes_q <= batteryLevel;
          `SDR_OPT_FLASH: errRes_q <= fl_q;
          default:        errRes_q <= 16'h0000;
        endcase
      end
      wd_q <= (errClr && opt == `SDR_OPT_WDOG) ? {15'h0, wdogEvent}
              : wd_q + {15'h0, wdogEvent && wd_q != 16'hffff};
      ov_q <= (errClr && opt == `SDR_OPT_OVR) ? {15'h0, overrunEvent}
              : ov_q + {15'h0, overrunEvent && ov_q != 16'hffff};
      low_q <= (errClr && opt == `SDR_OPT_LOWV) ? {15'h0, lowSupplyEvent}
               : low_q + {15'h0, lowSupplyEvent && low_q != 16'hffff};
      fl_q <= (errClr && opt == `SDR_OPT_FLASH) ? {15'h0, flashErrEvent}
              : fl_q + {15'h0, flashErrEvent && fl_q != 16'hffff};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q  <= `SDR_RST_ADDR;
      en_q    <= 1'b0;
      tt_q    <= 7'h00;
      nn_q    <= 6'h00;
      base_q  <= 8'h00;
      midx_q  <= 8'h00;
      sig_q   <= 32'h0;
      istat_q <= 4'h0;
      imask_q <= 4'h0;
      irq     <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      irq <= |(istat_q & imask_q);
      istat_q <= (apbWr && paddr == `SDR_OFS_ISTAT)
                 ? (istat_q & ~pwdata[3:0]) | isSet : istat_q | isSet;
      pready  <= psel & ~penable;
      if (psel && !penable) begin
        pslverr <= paddr[1:0] != 2'b00 || paddr > `SDR_OFS_ERRCNT;
        case (paddr)
          `SDR_OFS_CTRL:   prdata <= {23'h0, en_q, 1'b0, addr_q};
          `SDR_OFS_TIMVAL: prdata <= {18'h0, nn_q, 1'b0, tt_q};
          `SDR_OFS_BASE:   prdata <= {24'h0, base_q};
          `SDR_OFS_MIDX:   prdata <= {24'h0, midx_q};
          `SDR_OFS_MDATA:  prdata <= mem[midx_q];
          `SDR_OFS_SIG:    prdata <= sig_q;
          `SDR_OFS_ERRMON: prdata <= {16'h0, errRes_q};
          `SDR_OFS_STATUS: prdata <= {25'h0, pst_q, sending_q,
                                      tmrRun_q, dataVal_q, measReq};
          `SDR_OFS_ISTAT:  prdata <= {28'h0, istat_q};
          `SDR_OFS_IMASK:  prdata <= {28'h0, imask_q};
          `SDR_OFS_ERRCNT: prdata <= {ov_q, wd_q};
          default:         prdata <= 32'h0;
        endcase
      end
      if (apbWr) begin
        case (paddr)
          `SDR_OFS_CTRL: begin
            addr_q <= pwdata[6:0] == 7'h7f ? addr_q : pwdata[6:0];
            en_q   <= pwdata[`SDR_CTRL_EN];
          end
          `SDR_OFS_TIMVAL: begin
            tt_q <= pwdata[6:0];
            nn_q <= (pwdata[13:8] > `SDR_NN_MAX) ? `SDR_NN_MAX
                                                 : pwdata[13:8];
          end
          `SDR_OFS_BASE:  base_q <= pwdata[7:0];
          `SDR_OFS_MIDX:  midx_q <= pwdata[7:0];
          `SDR_OFS_MDATA: midx_q <= midx_q + 8'h01;
          `SDR_OFS_SIG:   sig_q <= pwdata;
          `SDR_OFS_IMASK: imask_q <= pwdata[3:0];
          default: midx_q <= midx_q;
        endcase
      end
    end
  end
endmodule // sdr_responder

// >>> sim/sdr_responder_asserts.sv
`timescale 1ns/100ps
module sdr_responder_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        measReq,
  input wire logic        txValid,
  input wire logic [7:0]  txChar,
  input wire logic        txReady
);
  wire bad = paddr > 8'h2c || paddr[1:0] != 2'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence setupS;
    ce && psel && !penable;
  endsequence
  sequence crS;
    txValid && txReady && txChar == 8'h0d;
  endsequence
  AST_PREADY: assert property (setupS |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  AST_ERR_SET: assert property (setupS ##0 bad |=> pslverr && !prdata)
    else $error("unmapped access not refused");
  AST_ERR_CLR: assert property (setupS ##0 !bad |=> !pslverr)
    else $error("mapped access refused");
  AST_TX_HOLD: assert property (txValid && !txReady |=>
    txValid && $stable(txChar)) else $error("reply char dropped");
  AST_TX_GAP: assert property (txValid && txReady |=> !txValid)
    else $error("no gap after reply char");
  AST_CRLF: assert property (crS |=> !txValid ##[1:2]
    txValid && txChar == 8'h0a) else $error("line feed missing");
  AST_ASCII: assert property (txValid |-> !txChar[7])
    else $error("reply char not ascii");
  AST_RST_QUIET: assert property ($fell(rst) |->
    !txValid && !irq && !measReq && !pready)
    else $error("outputs active right after reset");
endmodule // sdr_responder_asserts

bind sdr_responder sdr_responder_asserts u_chk (.clk, .rst, .ce, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .irq, .measReq, .txValid,
  .txChar, .txReady);

// >>> sim/sdr_recorder_model.sv
`timescale 1ns/100ps
module sdr_recorder_model #(
  parameter int BRK = 12
) (
  input  wire logic       clk,
  input  wire logic       txValid,
  input  wire logic [7:0] txChar,
  output logic            port2Line,
  output logic            rxValid,
  output logic [7:0]      rxChar,
  output logic            txReady
);
  string rsp = "";
  bit    slow = 1'b0;
  initial begin
    port2Line = 1'b0;
    rxValid = 1'b0;
    rxChar = 8'h00;
    txReady = 1'b0;
  end
  // Slow mode drops txReady every other cycle
  always @(posedge clk) begin
    if (txValid && txReady)
      rsp = {rsp, string'(txChar)};
    txReady <= slow ? !txReady : 1'b1;
  end
  task automatic cmd(input bit brk, input string s);
    rsp = "";
    if (brk) begin
      @(posedge clk);
      port2Line <= 1'b1;
      repeat (BRK) @(posedge clk);
      port2Line <= 1'b0;
      repeat (2) @(posedge clk);
    end
    foreach (s[i]) begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxChar <= s[i];
    end
    @(posedge clk);
    rxValid <= 1'b0;
    // Stale char inverted so it cannot pass as valid
    rxChar <= ~rxChar;
  endtask
endmodule // sdr_recorder_model

// >>> sim/test_sdr12_sensor_responder.sv
`timescale 1ns/100ps
module test_sdi12_sensor_responder;
  typedef struct {
    bit    b;
    string c;
    string e;
  } sdr_row_t;
  localparam string NL = "\015\012";
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic        port2Line, rxValid, txValid, txReady, measReq, rdErr;
  logic        wdogEvent, overrunEvent, lowSupplyEvent, flashErrEvent;
  logic [7:0]  paddr, rxChar, txChar;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] val [6];
  int          ex [5];
  int          miscompares = 0;
  int          total_checks = 0;
  sdr_row_t    rows [11];

  sdr_responder #(.SEC_CYC(32'd20), .BREAK_CYC(32'd8),
    .ID_STR(64'h4142_4344_4546_4748), // Arbitrary value
    .FW_REV(24'h32_33_34)) u_dut ( // Arbitrary value
    .clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .port2Line, .rxValid, .rxChar, .txValid,
    .txChar, .txReady, .measReq, .wdogEvent, .overrunEvent,
    .lowSupplyEvent, .flashErrEvent, .batteryLevel(16'h1234));
  sdr_recorder_model u_rec (.clk, .txValid, .txChar, .port2Line,
    .rxValid, .rxChar, .txReady);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic string hx(input logic [31:0] v);
    return $sformatf("%h", v);
  endfunction
  function automatic string hv(input int i);
    return {"+", hx(val[i])};
  endfunction
  task automatic chk(input string w, s, e);
    total_checks++;
    if (s != e) begin
      miscompares++;
      $display("unexpected %s: expected %s seen %s", w, e, s);
    end
  endtask
  task automatic apb(input bit w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Whole reply compared, so a stray trailing char is caught too
  task automatic run(input bit brk, input string c, e);
    u_rec.cmd(brk, c);
    for (int i = 0; i < 300 && u_rec.rsp.len() < e.len(); i++)
      @(posedge clk);
    repeat (20) @(posedge clk);
    chk(c, u_rec.rsp, e);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    {rst, ce} = 2'b11;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {wdogEvent, overrunEvent, lowSupplyEvent, flashErrEvent} = 4'h0;
    for (int i = 0; i < 6; i++)
      val[i] = 32'h5e1f_0a00 + i;
    ex = '{2, 1, 3, 32'h1234, 4};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset", $sformatf("%b", {txValid, irq, measReq, pready}), "0000");
    apb(1, 8'h00, 32'h0000_0131);
    apb(0, 8'h00, 32'h0);
    chk("ctrl", hx(rd), "00000131");
    apb(0, 8'h30, 32'h0);
    chk("unmapped", {hx(rd), $sformatf("%b", rdErr)}, "000000001");
    apb(1, 8'h04, 32'h0000_0200);
    apb(1, 8'h08, 32'h0);
    apb(1, 8'h0c, 32'h0);
    for (int i = 0; i < 6; i++)
      apb(1, 8'h10, val[i]);
    rows = '{'{0, "1M!", ""},
             '{1, "1M!", {"100002", NL}},
             '{0, "1D0!", {"1", hv(0), hv(1), NL}},
             '{0, "1M1!", {"100002", NL}},
             '{0, "1D0!", {"1", hv(2), hv(3), NL}},
             '{0, "1M2!", {"100002", NL}},
             '{0, "2M!", ""},
             '{0, "1D0!", {"1", hv(4), hv(5), NL}},
             '{0, "1I!", {"113ABCDEFGH234", NL}},
             '{0, "1!", {"1", NL}},
             '{0, "1D1!", {"1", NL}}};
    foreach (rows[i]) begin
      u_rec.slow = (i > 3);
      run(rows[i].b, rows[i].c, rows[i].e);
    end
    apb(1, 8'h04, 32'h0000_0209);
    run(0, "1M!", {"100902", NL});
    chk("measReq", $sformatf("%b", measReq), "1");
    run(0, "1D0!", "");
    u_rec.rsp = "";
    apb(1, 8'h14, 32'h1);
    repeat (40) @(posedge clk);
    chk("srq", u_rec.rsp, {"1", NL});
    run(0, "1D0!", {"1", hv(0), hv(1), NL});
    apb(1, 8'h24, 32'hf);
    apb(1, 8'h28, 32'h4);
    run(0, "1C!", {"100902", NL});
    repeat (200) @(posedge clk);
    run(0, "1D0!", "");
    chk("irq", $sformatf("%b", irq), "1");
    apb(1, 8'h24, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq", $sformatf("%b", irq), "0");
    apb(1, 8'h14, 32'h1);
    apb(1, 8'h04, 32'h0000_0200);
    repeat (40) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      wdogEvent <= (i < 2);
      overrunEvent <= (i < 1);
      lowSupplyEvent <= (i < 3);
      flashErrEvent <= 1'b1;
      @(posedge clk);
      {wdogEvent, overrunEvent, lowSupplyEvent, flashErrEvent} <= 4'h0;
    end
    apb(1, 8'h18, 32'h0bad_cafe);
    run(0, "1V!", {"100003", NL});
    run(0, "1D0!", {"1+00000002+00000001+0badcafe", NL});
    for (int o = 0; o < 5; o++) begin
      apb(1, 8'h1c, o);
      apb(0, 8'h1c, 32'h0);
      chk("errmon", hx(rd), hx(ex[o]));
      apb(1, 8'h1c, 32'h100 | o);
      apb(0, 8'h1c, 32'h0);
      chk("errmon idx", hx(rd), hx(ex[o]));
      apb(1, 8'h1c, o);
      apb(0, 8'h1c, 32'h0);
      chk("errmon clr", hx(rd), hx(o == 3 ? ex[o] : 0));
    end
    apb(1, 8'h00, 32'h0000_0105);
    run(0, "5!", {"5", NL});
    apb(1, 8'h00, 32'h0000_0005);
    run(0, "5!", "");
    @(posedge clk);
    ce <= 1'b0;
    wdogEvent <= 1'b1;
    @(posedge clk);
    wdogEvent <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    apb(1, 8'h1c, 32'h0);
    apb(0, 8'h1c, 32'h0);
    chk("ce freeze", hx(rd), "00000000");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset 2", $sformatf("%b", {txValid, irq, measReq, pready}), "0000");
    apb(0, 8'h00, 32'h0);
    chk("ctrl reset", hx(rd), "00000000");
    run(0, "5!", "");
    stop_test();
  end
endmodule // test_sdi12_sensor_responder
